// ===== design/mrd_pkg.sv
// package for the mode-register decode block: command codes, field layout
// assumes a single clock domain; command pins sampled on the rising edge
package mrd_pkg;
	// command pin encodings (cs, ras, cas, we all low = register set)
	localparam logic [3:0] CMD_REG_SET = 4'h0;
	// bank codes selecting the register
	localparam logic [1:0] BANK_MAIN = 2'h0;
	localparam logic [1:0] BANK_EXT1 = 2'h1;
	// address width of the x4/x8 organisations
	localparam int ADDR_W = 14;
	// main register field positions
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int RL_LSB = 4;
	localparam int TM_BIT = 7;
	localparam int DLLRST_BIT = 8;
	localparam int WR_LSB = 9;
	localparam int PD_BIT = 12;
	localparam int HI_BIT = 13;
	// main register codes
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] RL_CODE_MIN = 3'h2;
	localparam logic [2:0] RL_CODE_MAX = 3'h5;
	localparam logic [2:0] WR_CODE_MIN = 3'h1;
	localparam logic [2:0] WR_CODE_MAX = 3'h5;
	// burst beats and write recovery offsets
	localparam logic [3:0] BEATS_4 = 4'h4;
	localparam logic [3:0] BEATS_8 = 4'h8;
	localparam logic [2:0] WR_CODE_OFS = 3'h1;
	// first extended register field positions
	localparam int E_DLL_BIT = 0;
	localparam int E_DRV_BIT = 1;
	localparam int E_RTT0_BIT = 2;
	localparam int E_AL_LSB = 3;
	localparam int E_RTT1_BIT = 6;
	localparam int E_OCD_LSB = 7;
	localparam int E_DQSN_BIT = 10;
	localparam int E_RDQS_BIT = 11;
	localparam int E_QOFF_BIT = 12;
	// command bundle as sampled from the pins
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bank;
		logic [ADDR_W-1:0] addr;
	} mrd_cmd_t;
	// decoded main register settings
	typedef struct packed {
		logic [3:0] burst_beats;
		logic burst_order_sel;
		logic [2:0] read_latency_sel;
		logic vendor_test_sel;
		logic [2:0] write_recovery;
		logic powerdown_exit_sel;
		logic code_err;
	} mrd_main_t;
	// first extended register settings
	typedef struct packed {
		logic dll_disable;
		logic drive_weak;
		logic [1:0] odt_sel;
		logic [2:0] additive_latency;
		logic [2:0] ocd_prog;
		logic dqs_n_disable;
		logic rdqs_enable;
		logic output_disable;
	} mrd_ext1_t;
endpackage

// ===== design/mrd_field_decode.sv
// field decoder: turns a raw main register word into decoded settings
// assumes the word is stable; purely combinational
`timescale 1ns/100ps
module mrd_field_decode (
	// raw word
	input wire logic [mrd_pkg::ADDR_W-1:0] word_i,
	// decoded settings
	output mrd_pkg::mrd_main_t main_o
);
	logic [2:0] bl;
	logic [2:0] rl;
	logic [2:0] wr;

	// field extraction
	assign bl = word_i[mrd_pkg::BL_LSB +: 3];
	assign rl = word_i[mrd_pkg::RL_LSB +: 3];
	assign wr = word_i[mrd_pkg::WR_LSB +: 3];

	// decode; reserved codes raise the error flag rather than being ignored
	always_comb begin
		main_o = '0;
		main_o.burst_beats = (bl == mrd_pkg::BL_CODE_8) ? mrd_pkg::BEATS_8 :
			mrd_pkg::BEATS_4;
		main_o.burst_order_sel = word_i[mrd_pkg::BT_BIT];
		main_o.read_latency_sel = rl;
		main_o.vendor_test_sel = word_i[mrd_pkg::TM_BIT];
		main_o.write_recovery = wr + mrd_pkg::WR_CODE_OFS;
		main_o.powerdown_exit_sel = word_i[mrd_pkg::PD_BIT];
		main_o.code_err = (bl != mrd_pkg::BL_CODE_4 &&
			bl != mrd_pkg::BL_CODE_8) ||
			rl < mrd_pkg::RL_CODE_MIN || rl > mrd_pkg::RL_CODE_MAX ||
			wr < mrd_pkg::WR_CODE_MIN || wr > mrd_pkg::WR_CODE_MAX;
	end
endmodule

// ===== design/mrd_mode_regs.sv
// mode-register programming logic of the memory: main and first extended
// register, written by register-set commands from the controller pins.
// assumes pins are synchronous to ref_clk_i and the controller keeps timing.
//
// Operation
// - register-set with both bank bits low writes the main register
// - address bits 2:0 select burst length: 010 four, 011 eight beats
// - address bit 3 selects sequential or interleaved burst order
// - bits 6:4 give read latency, codes 010..101 mean two..five
// - bit 7 selects vendor test mode; controller keeps it zero
// - bit 8 set during main write resets the delay-locked loop
// - bits 11:9 give write recovery, codes 001..101 mean two..six
// - bit 12 picks fast or slow active power-down exit
// - bit 13 exists only on four- and eight-bit organisations
// - register fields are write-only, never read back on data pins
// - first extended register holds dll, drive, latency, odt, strobe bits
// - extended register undefined at power-up; controller must write it
// - extended write: select, strobes, enable, bank1 low, bank0 high
// - registers may be rewritten in normal operation when all idle
`timescale 1ns/100ps
module mrd_mode_regs #(
	parameter int ADDR_BITS = 14
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	// command pins as a bundle
	input mrd_pkg::mrd_cmd_t cmd_i,
	// bank state from the array side
	input wire logic all_idle_i,
	// decoded main settings
	output mrd_pkg::mrd_main_t main_o,
	output logic dll_reset_o,
	// first extended settings
	output mrd_pkg::mrd_ext1_t ext1_o,
	output logic main_valid_o,
	output logic ext1_valid_o
);
	logic [mrd_pkg::ADDR_W-1:0] main_operating_mode;
	logic [mrd_pkg::ADDR_W-1:0] masked_addr;
	logic reg_set;
	logic main_wr;
	logic ext1_wr;
	mrd_pkg::mrd_main_t next_main;

	// elaboration-time check on the organisation width
	if (ADDR_BITS != 13 && ADDR_BITS != 14) begin : g_bad_width
		$error("ADDR_BITS must be 13 or 14");
	end

	// the x16 part has no top address bit: it reads as zero
	assign masked_addr = (ADDR_BITS == 13) ?
		{1'b0, cmd_i.addr[mrd_pkg::ADDR_W-2:0]} : cmd_i.addr;

	// command decode; writes outside idle are dropped, not half applied
	assign reg_set = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n} ==
		mrd_pkg::CMD_REG_SET && all_idle_i;
	assign main_wr = reg_set && cmd_i.bank == mrd_pkg::BANK_MAIN;
	assign ext1_wr = reg_set && cmd_i.bank == mrd_pkg::BANK_EXT1;

	// main register storage; write-only, no path to the data pins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			main_operating_mode <= '0;
		end else if (clk_en_i && main_wr) begin
			main_operating_mode <= masked_addr;
		end
	end

	// field decode of the stored word
	mrd_field_decode u_decode (
		.word_i(main_operating_mode),
		.main_o(next_main)
	);

	// registered decoded outputs; one cycle behind the stored word
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			main_o <= '0;
		end else if (clk_en_i) begin
			main_o <= next_main;
		end
	end

	// dll reset pulse: one cycle, only from a main write with bit 8 set
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dll_reset_o <= 1'b0;
		end else if (clk_en_i) begin
			dll_reset_o <= main_wr && masked_addr[mrd_pkg::DLLRST_BIT];
		end
	end

	// first extended register fields taken straight from the address pins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext1_o <= '0;
		end else if (clk_en_i && ext1_wr) begin
			ext1_o.dll_disable <= masked_addr[mrd_pkg::E_DLL_BIT];
			ext1_o.drive_weak <= masked_addr[mrd_pkg::E_DRV_BIT];
			ext1_o.odt_sel <= {masked_addr[mrd_pkg::E_RTT1_BIT],
				masked_addr[mrd_pkg::E_RTT0_BIT]};
			ext1_o.additive_latency <= masked_addr[mrd_pkg::E_AL_LSB +: 3];
			ext1_o.ocd_prog <= masked_addr[mrd_pkg::E_OCD_LSB +: 3];
			ext1_o.dqs_n_disable <= masked_addr[mrd_pkg::E_DQSN_BIT];
			ext1_o.rdqs_enable <= masked_addr[mrd_pkg::E_RDQS_BIT];
			ext1_o.output_disable <= masked_addr[mrd_pkg::E_QOFF_BIT];
		end
	end

	// contents are undefined until first written; flag that for the core
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			main_valid_o <= 1'b0;
			ext1_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			if (main_wr) begin
				main_valid_o <= 1'b1;
			end
			if (ext1_wr) begin
				ext1_valid_o <= 1'b1;
			end
		end
	end
endmodule

// ===== bench/mrd_chk.sv
// checker: register-set take, decode and refusal
// assumes one clock; bound to mrd_mode_regs below
`timescale 1ns/100ps
module mrd_chk (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input mrd_pkg::mrd_cmd_t cmd_i,
	input wire logic all_idle_i,
	input mrd_pkg::mrd_main_t main_o,
	input wire logic dll_reset_o,
	input mrd_pkg::mrd_ext1_t ext1_o,
	input wire logic main_valid_o,
	input wire logic ext1_valid_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// all four strobes low on an enabled edge
	wire rs = clk_en_i & ~|cmd_i[19:16];
	wire [13:0] a = cmd_i.addr;
	wire [2:0] mb = {a[3], a[7], a[12]};
	// strobe, read strobe and output-off bits sit in ascending order
	wire [12:0] e = {a[0], a[1], a[6], a[2], a[5:3], a[9:7], a[10], a[11],
		a[12]};
	sequence s_main; rs && all_idle_i && cmd_i.bank == 2'h0; endsequence
	sequence s_ext; rs && all_idle_i && cmd_i.bank == 2'h1; endsequence
	a_main_valid: assert property (s_main |=> main_valid_o)
		else $error("main write lost");
	a_dll_pulse: assert property (s_main |=> dll_reset_o == $past(a[8]))
		else $error("dll reset wrong");
	a_burst_len: assert property (s_main ##0 a[2:1] == 2'h1 |=> ##1
		main_o.burst_beats == ($past(a[0], 2) ? 4'h8 : 4'h4))
		else $error("burst length wrong");
	a_read_lat: assert property (s_main |=> ##1
		main_o.read_latency_sel == $past(a[6:4], 2)) else $error("latency");
	a_wr_rec: assert property (s_main ##0 a[11:9] inside {[3'h1:3'h5]}
		|=> ##1 main_o.write_recovery == $past(a[11:9], 2) + 3'h1)
		else $error("write recovery wrong");
	a_mode_bits: assert property (s_main |=> ##1
		{main_o.burst_order_sel, main_o.vendor_test_sel,
		main_o.powerdown_exit_sel} == $past(mb, 2))
		else $error("mode bits wrong");
	a_ext1_take: assert property (s_ext |=>
		ext1_valid_o && ext1_o == $past(e))
		else $error("ext1 write wrong");
	a_busy_refused: assert property (rs && !all_idle_i && cmd_i.bank == 2'h0
		|=> !dll_reset_o ##1 $stable(main_o)) else $error("busy write taken");
endmodule
bind mrd_mode_regs mrd_chk i_mrd_chk (.ref_clk_i, .arst_n_i, .clk_en_i,
	.cmd_i, .all_idle_i, .main_o, .dll_reset_o, .ext1_o, .main_valid_o,
	.ext1_valid_o);

// ===== bench/mrd_ctrl_model.sv
// controller model: drives register-set commands on the pins
// assumes callers run in the clock's domain
`timescale 1ns/100ps
module mrd_ctrl_model #(
	parameter int MRD_CYC = 2
) (
	input wire logic clk_i,
	output mrd_pkg::mrd_cmd_t cmd_o
);
	initial cmd_o = {4'hF, 16'h0};
	// idle pins carry the inverted word so a stale value never passes
	task automatic mrs(input logic [1:0] ba, input logic [13:0] w);
		@(posedge clk_i);
		cmd_o <= {4'h0, ba, w};
		@(posedge clk_i);
		cmd_o <= {4'hF, ~ba, ~w};
		repeat (MRD_CYC) @(posedge clk_i);
	endtask
endmodule

// ===== bench/tb_sdram_mode_register_decode.sv
// bench: extended and main writes, busy and frozen refusals
// assumes the controller model drives the command pins
`timescale 1ns/100ps
module tb_sdram_mode_register_decode;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic clk_en_i = 1'b0;
	logic all_idle_i = 1'b0;
	mrd_pkg::mrd_cmd_t cmd;
	mrd_pkg::mrd_main_t main_o;
	mrd_pkg::mrd_ext1_t ext1_o;
	logic dll_reset_o;
	logic main_valid_o;
	logic ext1_valid_o;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_dll = 0;
	initial forever #50 ref_clk_i = ~ref_clk_i;
	mrd_ctrl_model i_mrd_ctrl_model (.clk_i(ref_clk_i), .cmd_o(cmd));
	mrd_mode_regs i_mrd_mode_regs (.ref_clk_i, .arst_n_i, .clk_en_i,
		.cmd_i(cmd), .all_idle_i, .main_o, .dll_reset_o, .ext1_o,
		.main_valid_o, .ext1_valid_o);
	task automatic ck(input string nm, input logic [15:0] ex, act);
		n_checks++;
		if (act !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, act);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// dll reset pulses seen at a clock edge; a stretched pulse counts twice
	always @(posedge ref_clk_i) begin
		if (dll_reset_o === 1'b1) begin
			n_dll <= n_dll + 1;
		end
	end
	// hang guard: the run needs about 64 cycles
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 300) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic t_ext();
		logic [13:0] w;
		// the third word tells every bit from its mirror image
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 14'h0AAA : (i == 1) ? 14'h1555 : 14'h048C;
			i_mrd_ctrl_model.mrs(2'h1, w);
			#1 ck("ext1", 16'({w[0], w[1], w[6], w[2], w[5:3], w[9:7],
				w[10], w[11], w[12]}), 16'(ext1_o));
		end
		ck("valid", 16'h1, 16'({main_valid_o, ext1_valid_o}));
		ck("ext dll", 16'h0, 16'(n_dll));
		$display("ext1 test done");
	endtask
	// every latency and recovery code, both lengths and orders
	task automatic t_main();
		logic [2:0] rl;
		logic [2:0] wr;
		logic b;
		mrd_pkg::mrd_main_t m;
		for (int i = 0; i < 5; i++) begin
			b = i[0];
			rl = 3'h2 + 3'(i % 4);
			wr = 3'h1 + 3'(i);
			m = '{b ? 4'h8 : 4'h4, b, rl, 1'b0, wr + 3'h1, i[1], 1'b0};
			i_mrd_ctrl_model.mrs(2'h0, {1'b0, i[1], wr, b, 1'b0, rl, b,
				2'h1, b});
			#1 ck("main", 16'(m), 16'(main_o));
		end
		ck("dll pulses", 16'h2, 16'(n_dll));
		$display("main test done");
	endtask
	// busy banks, then a frozen clock: the word must stay
	task automatic t_refuse();
		@(posedge ref_clk_i);
		all_idle_i <= 1'b0;
		i_mrd_ctrl_model.mrs(2'h0, 14'h1B5B);
		all_idle_i <= 1'b1;
		clk_en_i <= 1'b0;
		i_mrd_ctrl_model.mrs(2'h0, 14'h1B5B);
		clk_en_i <= 1'b1;
		// two enabled edges let a wrongly taken word reach the outputs
		repeat (2) @(posedge ref_clk_i);
		// last taken word: burst 4, latency code 2, recovery six clocks
		#1 ck("kept", 16'h1098, 16'(main_o));
		ck("busy dll", 16'h2, 16'(n_dll));
		$display("refusal test done");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		clk_en_i <= 1'b1;
		all_idle_i <= 1'b1;
		@(posedge ref_clk_i);
		#1 ck("reset", 16'h0, 16'({main_valid_o, ext1_valid_o}));
		// word zero decodes as burst 4, recovery 1, reserved codes flagged
		ck("reset word", 16'h1005, 16'(main_o));
		t_ext();
		t_main();
		t_refuse();
		give_verdict();
	end
endmodule
